/* File: common/cmx_pkg.sv */
// Purpose: constants for the comparator input select register bank
// Assumes: 8-bit special-function register space, paged
// Notes:   channel-select lines are one-hot, bit index = channel code
`default_nettype none
package cmx_pkg;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned PAGE_W  = 8;
  localparam int unsigned SEL_W   = 16;

  // register addresses and page
  localparam logic [7:0] SFR_PAGE_CMX      = 8'h00;
  localparam logic [7:0] ADDR_CMP1_SELECT  = 8'h9E;
  localparam logic [7:0] ADDR_CMP0_SELECT  = 8'h9F;

  // field layout
  localparam int unsigned NEG_LSB = 4;
  localparam int unsigned NEG_MSB = 7;
  localparam int unsigned POS_LSB = 0;
  localparam int unsigned POS_MSB = 3;

  // reset value: negative picks ground, positive picks main supply
  localparam logic [7:0] SELECT_RESET = 8'hFF;

  // negative side channel codes
  localparam logic [3:0] NEG_LAST_PIN   = 4'h6;
  localparam logic [3:0] CODE_TOUCH_REF = 4'hC;
  localparam logic [3:0] CODE_HALF_SUP  = 4'hD;
  localparam logic [3:0] NEG_CORE_SUP   = 4'hE;
  localparam logic [3:0] NEG_GROUND     = 4'hF;
  // positive side channel codes
  localparam logic [3:0] POS_LAST_PIN   = 4'h7;
  localparam logic [3:0] POS_BATT_SUP   = 4'hE;
  localparam logic [3:0] POS_MAIN_SUP   = 4'hF;

  typedef enum logic [1:0] {
    CMX_SIDE_NEG = 2'b01,
    CMX_SIDE_POS = 2'b10
  } cmx_side_e;
endpackage
`default_nettype wire

/* File: hdl/cmx_decode.sv */
// Purpose: decode one 4-bit select field into one-hot channel lines
// Assumes: field is a stored register value on the same clock
// Notes:   reserved codes give an all-zero select word
`timescale 1ns/100ps
`default_nettype none
module cmx_decode
  import cmx_pkg::*;
(
  // field in
  input  wire logic [3:0]       field_i,
  input  wire cmx_side_e        side_i,
  // one-hot out
  output logic [SEL_W-1:0]      sel_o
);
  // does this code name a real channel on the given side
  function automatic logic code_valid(input logic [3:0] c,
                                      input cmx_side_e s);
    logic ok;
    ok = 1'b0;
    if (c >= CODE_TOUCH_REF)
      ok = 1'b1;
    else if (s == CMX_SIDE_NEG)
      ok = (c <= NEG_LAST_PIN);
    else
      ok = (c <= POS_LAST_PIN);
    return ok;
  endfunction

  // one-hot decode; both comparators share this table
  always_comb
  begin
    sel_o = '0;
    if (code_valid(field_i, side_i))
      sel_o[field_i] = 1'b1;
  end
endmodule
`default_nettype wire

/* File: hdl/cmx_select_regs.sv */
// Purpose: comparator input select registers and their decoded selects
// Assumes: core drives single-cycle read/write strobes with the page
// Notes:   read data is registered one cycle after the read strobe
`timescale 1ns/100ps
`default_nettype none
// Function
// - Comparator-zero select register lives at 0x9F page 0x0, 8 bits RW.
// - Comparator-one select register lives at 0x9E page 0x0, 8 bits RW.
// - Bits 7:4 of the zero register choose its negative input.
// - Bits 3:0 of the zero register choose its positive input.
// - The one register has the same negative/positive field layout.
// - Negative codes 0-6 pick odd port pins; C touch, D half, E core, F gnd.
// - Positive codes 0-7 pick even port pins; C touch, D half, E bat, F main.
// - Code D on any field routes half the comparator supply.
// - Both registers reset to all ones.
// - Comparator one decodes with the same table, reserved codes included.
module cmx_select_regs
  import cmx_pkg::*;
(
  // clock and reset
  input  wire logic                 CLK_I,
  input  wire logic                 NRST_I,
  // special-function register port
  input  wire logic [PAGE_W-1:0]    SFR_PAGE_I,
  input  wire logic [ADDR_W-1:0]    SFR_ADDR_I,
  input  wire logic                 SFR_WR_I,
  input  wire logic                 SFR_RD_I,
  input  wire logic [DATA_W-1:0]    SFR_WDATA_I,
  output logic [DATA_W-1:0]         SFR_RDATA_O,
  output logic                      SFR_HIT_O,
  // analog multiplexer select lines, one-hot by code
  output logic [SEL_W-1:0]          CMP0_NEG_SEL_O,
  output logic [SEL_W-1:0]          CMP0_POS_SEL_O,
  output logic [SEL_W-1:0]          CMP1_NEG_SEL_O,
  output logic [SEL_W-1:0]          CMP1_POS_SEL_O
);
  logic [DATA_W-1:0] comparator0_input_select_ff;
  logic [DATA_W-1:0] comparator1_input_select_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic              hit_ff;
  logic              page_ok;
  logic              sel0;
  logic              sel1;

  // address decode; other pages leave these registers alone
  assign page_ok = (SFR_PAGE_I == SFR_PAGE_CMX);
  assign sel0    = page_ok && (SFR_ADDR_I == ADDR_CMP0_SELECT);
  assign sel1    = page_ok && (SFR_ADDR_I == ADDR_CMP1_SELECT);

  // comparator zero select register, every bit stored as written
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      comparator0_input_select_ff <= SELECT_RESET;
    else if (SFR_WR_I && sel0)
      comparator0_input_select_ff <= SFR_WDATA_I;
  end

  // comparator one select register
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      comparator1_input_select_ff <= SELECT_RESET;
    else if (SFR_WR_I && sel1)
      comparator1_input_select_ff <= SFR_WDATA_I;
  end

  // registered read path; unmapped reads return zero with hit low
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      rdata_ff <= 8'h00;
      hit_ff   <= 1'b0;
    end
    else if (SFR_RD_I)
    begin
      hit_ff <= sel0 || sel1;
      if (sel0)
        rdata_ff <= comparator0_input_select_ff;
      else if (sel1)
        rdata_ff <= comparator1_input_select_ff;
      else
        rdata_ff <= 8'h00;
    end
  end

  assign SFR_RDATA_O = rdata_ff;
  assign SFR_HIT_O   = hit_ff;

  // field decoders; the selects follow the register with no extra delay
  // because the analog mux must settle before software samples
  cmx_decode u_dec0n (
    .field_i (comparator0_input_select_ff[NEG_MSB:NEG_LSB]),
    .side_i  (CMX_SIDE_NEG),
    .sel_o   (CMP0_NEG_SEL_O)
  );
  cmx_decode u_dec0p (
    .field_i (comparator0_input_select_ff[POS_MSB:POS_LSB]),
    .side_i  (CMX_SIDE_POS),
    .sel_o   (CMP0_POS_SEL_O)
  );
  cmx_decode u_dec1n (
    .field_i (comparator1_input_select_ff[NEG_MSB:NEG_LSB]),
    .side_i  (CMX_SIDE_NEG),
    .sel_o   (CMP1_NEG_SEL_O)
  );
  cmx_decode u_dec1p (
    .field_i (comparator1_input_select_ff[POS_MSB:POS_LSB]),
    .side_i  (CMX_SIDE_POS),
    .sel_o   (CMP1_POS_SEL_O)
  );

  // a write lands in the register one edge later
  AST_WR0: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    SFR_WR_I && sel0 |=> comparator0_input_select_ff == $past(SFR_WDATA_I))
    else $error("cmp0 select write lost");
  AST_WR1: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    SFR_WR_I && sel1 |=> comparator1_input_select_ff == $past(SFR_WDATA_I))
    else $error("cmp1 select write lost");
  // other addresses never disturb the registers
  AST_HOLD: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    !(SFR_WR_I && (sel0 || sel1)) |=>
      $stable(comparator0_input_select_ff) &&
      $stable(comparator1_input_select_ff))
    else $error("select register changed without write");
  // ground on negative and main supply on positive after reset
  AST_RST: assert property (@(posedge CLK_I)
    $rose(NRST_I) |-> CMP0_NEG_SEL_O[NEG_GROUND] &&
      CMP0_POS_SEL_O[POS_MAIN_SUP] && CMP1_NEG_SEL_O[NEG_GROUND] &&
      CMP1_POS_SEL_O[POS_MAIN_SUP])
    else $error("reset selection wrong");
  // a written pin code on either field drives its own line and no other
  AST_NEG0: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    SFR_WR_I && sel0 && SFR_WDATA_I[7:4] <= NEG_LAST_PIN |=>
      CMP0_NEG_SEL_O == (16'h0001 << $past(SFR_WDATA_I[7:4])))
    else $error("cmp0 negative pin decode wrong");
  AST_POS1: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    SFR_WR_I && sel1 && SFR_WDATA_I[3:0] <= POS_LAST_PIN |=>
      CMP1_POS_SEL_O == (16'h0001 << $past(SFR_WDATA_I[3:0])))
    else $error("cmp1 positive pin decode wrong");
  AST_NEG1: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    SFR_WR_I && sel1 && SFR_WDATA_I[7:4] <= NEG_LAST_PIN |=>
      CMP1_NEG_SEL_O == (16'h0001 << $past(SFR_WDATA_I[7:4])))
    else $error("cmp1 negative pin decode wrong");
  AST_POS0: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    SFR_WR_I && sel0 && SFR_WDATA_I[3:0] <= POS_LAST_PIN |=>
      CMP0_POS_SEL_O == (16'h0001 << $past(SFR_WDATA_I[3:0])))
    else $error("cmp0 positive pin decode wrong");
  // internal references land on their own lines
  AST_TOUCH: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    comparator0_input_select_ff[3:0] == CODE_TOUCH_REF |->
      CMP0_POS_SEL_O == 16'h1000)
    else $error("touch reference not selected");
  AST_CORE: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    comparator0_input_select_ff[7:4] == NEG_CORE_SUP |->
      CMP0_NEG_SEL_O == 16'h4000)
    else $error("core supply not selected");
  // half-supply code reaches its line
  AST_HALF: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    comparator1_input_select_ff[7:4] == CODE_HALF_SUP |->
      CMP1_NEG_SEL_O == 16'h2000)
    else $error("half supply not selected");
  // reserved negative code 7 selects nothing yet reads back
  AST_RSV: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    comparator0_input_select_ff[7:4] == 4'h7 |-> CMP0_NEG_SEL_O == 16'h0000)
    else $error("reserved code drove a select");
  // positive codes 8 to B are reserved on comparator one as well
  AST_RSVP: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    comparator1_input_select_ff[3] && !comparator1_input_select_ff[2] |->
      CMP1_POS_SEL_O == 16'h0000)
    else $error("reserved positive code drove a select");
  // register readback for comparator one
  AST_RD1: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    SFR_RD_I && sel1 |=>
      SFR_RDATA_O == $past(comparator1_input_select_ff) && SFR_HIT_O)
    else $error("cmp1 readback wrong");
  // unmapped reads give zero and no hit
  AST_RDMISS: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    SFR_RD_I && !sel0 && !sel1 |=> !SFR_HIT_O && SFR_RDATA_O == 8'h00)
    else $error("unmapped read answered");
  AST_RD: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    SFR_RD_I && sel0 && !SFR_WR_I |=>
      SFR_RDATA_O == $past(comparator0_input_select_ff) && SFR_HIT_O)
    else $error("cmp0 readback wrong");
endmodule
`default_nettype wire

/* File: sim/tb_comparator_input_mux_select.sv */
// Purpose: self-checking bench for the comparator input select registers
// Assumes: one clock, register port driven 1 ns after each rising edge
// Notes:   expected select words are rebuilt here from the channel tables
`timescale 1ns/100ps
`default_nettype none
module tb_comparator_input_mux_select;
  import cmx_pkg::*;
  logic              clk;
  logic              nrst;
  logic [PAGE_W-1:0] page;
  logic [ADDR_W-1:0] addr;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              hit;
  logic [SEL_W-1:0]  n0, p0, n1, p1;
  int                mismatches;
  int                checks_done;

  cmx_select_regs i_dut (.CLK_I(clk), .NRST_I(nrst), .SFR_PAGE_I(page),
    .SFR_ADDR_I(addr), .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_WDATA_I(wdata),
    .SFR_RDATA_O(rdata), .SFR_HIT_O(hit), .CMP0_NEG_SEL_O(n0),
    .CMP0_POS_SEL_O(p0), .CMP1_NEG_SEL_O(n1), .CMP1_POS_SEL_O(p1));

  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // one-hot by code; gaps in each table give an empty word
  function automatic logic [15:0] exp_sel(input logic [3:0] c, input bit neg);
    logic [3:0] last;
    last = neg ? 4'h6 : 4'h7;
    return (c <= last || c >= 4'hC) ? (16'h0001 << c) : 16'h0000;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one strobe cycle and one idle cycle, so no strobe is driven twice
  // in one time step; read data holds until the next read strobe
  task automatic access(input logic [7:0] pg, input logic [7:0] ad,
                        input logic w, input logic [7:0] d);
    page = pg;
    addr = ad;
    wr = w;
    rd = !w;
    wdata = d;
    @(posedge clk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic read_chk(input logic [7:0] pg, input logic [7:0] ad,
                          input logic [7:0] d, input logic h);
    access(pg, ad, 1'b0, 8'h00);
    check({8'h00, rdata}, {8'h00, d});
    check({15'h0000, hit}, {15'h0000, h});
  endtask

  task automatic reset_values();
    check(n0, 16'h8000);
    check(p0, 16'h8000);
    check(n1, 16'h8000);
    check(p1, 16'h8000);
    read_chk(8'h00, 8'h9F, 8'hFF, 1'b1);
    read_chk(8'h00, 8'h9E, 8'hFF, 1'b1);
  endtask

  // every code on every field, opposite codes in the two halves;
  // pin setup for analog use is software's job and not modelled
  task automatic sweep();
    logic [3:0] c;
    for (int i = 0; i < 16; i++)
    begin
      c = 4'(i);
      access(8'h00, 8'h9F, 1'b1, {c, ~c});
      access(8'h00, 8'h9E, 1'b1, {~c, c});
      check(n0, exp_sel(c, 1'b1));
      check(p0, exp_sel(~c, 1'b0));
      check(n1, exp_sel(~c, 1'b1));
      check(p1, exp_sel(c, 1'b0));
      read_chk(8'h00, 8'h9F, {c, ~c}, 1'b1);
      read_chk(8'h00, 8'h9E, {~c, c}, 1'b1);
    end
  endtask

  // wrong page or neighbour address must leave both registers alone
  task automatic misses();
    access(8'h01, 8'h9F, 1'b1, 8'h00);
    access(8'h00, 8'h9D, 1'b1, 8'h00);
    check(n0, 16'h8000);
    read_chk(8'h00, 8'h9F, 8'hF0, 1'b1);
    read_chk(8'h01, 8'h9E, 8'h00, 1'b0);
    read_chk(8'h00, 8'h9D, 8'h00, 1'b0);
    read_chk(8'h00, 8'h9E, 8'h0F, 1'b1);
  endtask

  // reset in mid-run must bring both registers back to all ones
  task automatic mid_reset();
    nrst = 1'b0;
    @(posedge clk);
    #1;
    check(n1, 16'h8000);
    check(p0, 16'h8000);
    check({15'h0000, hit}, 16'h0000);
    @(posedge clk);
    #1;
    nrst = 1'b1;
    check(n0, 16'h8000);
    check(p1, 16'h8000);
    read_chk(8'h00, 8'h9F, 8'hFF, 1'b1);
    read_chk(8'h00, 8'h9E, 8'hFF, 1'b1);
  endtask

  task automatic complete_run();
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence
  initial
  begin
    mismatches = 0;
    checks_done = 0;
    nrst = 1'b0;
    page = 8'h00;
    addr = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    reset_values();
    sweep();
    misses();
    mid_reset();
    complete_run();
  end

  // the run needs about 160 cycles; this cuts a hang short
  initial
  begin
    #20000;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
